//--- design/sacc_pkg.sv
// constants, register map and state type of the converter control block
// Summary of operation
// - converter powered only while enable set
// - only selected input reaches sample stage
// - software start begins one conversion
// - completion clears busy, sets flag, interrupts
// - upper 8 bits high, lower 4 low
// - result code scales linearly, full scale 4095
// - hardware trigger from PWM or start pin
// - hardware start also sets busy bit
// - start pin taken from one of two
// - triggers qualified by source and type fields
// - programmable delay before triggered conversion
// - starts while busy silently discarded
// - comparator checks result against 12-bit constant
// - comparison updated only at completion
// - compare output sense set by polarity
// - compare event asserts PWM fault brake
// - brake events set flag; software clears
// - brake interrupt separate with own enable
// - no new start while done flag set
// - source codes pick PWM0, PWM2, PWM4, pin
// - channel codes 0-7 inputs, 8 band-gap
package sacc_pkg;
	localparam int ADDR_W = 6;
	localparam int RES_W  = 12;
	localparam int DLY_W  = 8;
	localparam int NSEL   = 9;
	localparam logic [ADDR_W-1:0] OFS_CON0   = 6'h00;
	localparam logic [ADDR_W-1:0] OFS_CON1   = 6'h04;
	localparam logic [ADDR_W-1:0] OFS_CON2   = 6'h08;
	localparam logic [ADDR_W-1:0] OFS_RES_H  = 6'h0c;
	localparam logic [ADDR_W-1:0] OFS_RES_L  = 6'h10;
	localparam logic [ADDR_W-1:0] OFS_CMP_H  = 6'h14;
	localparam logic [ADDR_W-1:0] OFS_CMP_L  = 6'h18;
	localparam logic [ADDR_W-1:0] OFS_BRAKE  = 6'h1c;
	localparam logic [ADDR_W-1:0] OFS_IRQEN  = 6'h20;
	localparam logic [ADDR_W-1:0] OFS_DELAY  = 6'h24;
	localparam logic [ADDR_W-1:0] OFS_AINDIS = 6'h28;
	// conv_control_zero
	localparam int B_DONE = 7;
	localparam int B_BUSY = 6;
	localparam int B_SRC  = 4;
	localparam int B_CHAN = 0;
	// conv_control_one
	localparam int B_PINSEL = 6;
	localparam int B_TYPE   = 2;
	localparam int B_HWTRIG = 1;
	localparam int B_ENABLE = 0;
	// conv_control_two
	localparam int B_BRKEN = 7;
	localparam int B_POL   = 6;
	localparam int B_CMPEN = 5;
	localparam int B_CMPO  = 4;
	// brake flag register and irq enables
	localparam int B_FBF   = 7;
	localparam int B_CIRQ  = 0;
	localparam int B_FBIRQ = 1;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [1:0] SRC_PWM0 = 2'h0;
	localparam logic [1:0] SRC_PWM2 = 2'h1;
	localparam logic [1:0] SRC_PWM4 = 2'h2;
	localparam logic [1:0] SRC_PIN  = 2'h3;
	localparam logic [1:0] TYP_FALL = 2'h0;
	localparam logic [1:0] TYP_RISE = 2'h1;
	localparam logic [1:0] TYP_CENT = 2'h2;
	localparam logic [1:0] TYP_END  = 2'h3;
	localparam logic [3:0] CHAN_BG  = 4'h8;
	typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_CONV} sacc_state_type;
endpackage : sacc_pkg

//--- design/sacc_top.sv
// converter control: registers, triggers, sequencing, result and comparator
`timescale 1ns/1ns
`default_nettype none
module sacc_top (
	// clock and reset
	input  wire logic        REF_CLK,
	input  wire logic        RESET,
	// avalon-mm slave
	input  wire logic [5:0]  AVS_ADDRESS,
	input  wire logic        AVS_READ,
	input  wire logic        AVS_WRITE,
	input  wire logic [3:0]  AVS_BYTEENABLE,
	input  wire logic [31:0] AVS_WRITEDATA,
	output logic      [31:0] AVS_READDATA,
	output logic             AVS_WAITREQUEST,
	// analog core
	output logic             CONV_POWER,
	output logic [8:0]       ANALOG_SEL,
	output logic [7:0]       DIGITAL_IN_DISABLE,
	output logic             CONV_START,
	input  wire logic        CONV_DONE,
	input  wire logic [11:0] CONV_DATA,
	// pwm generator
	input  wire logic [5:0]  PWM_OUT,
	input  wire logic        PWM_CENTER,
	input  wire logic        PWM_PERIOD_END,
	input  wire logic        BRAKE_EVENT,
	output logic             COMPARE_BRAKE,
	// external start pins
	input  wire logic        START_PIN_A,
	input  wire logic        START_PIN_B,
	// interrupt requests
	output logic             CONV_IRQ,
	output logic             FBRAKE_IRQ
);
	sacc_pkg::sacc_state_type state;
	logic [7:0]  con0;
	logic [7:0]  con1;
	logic [7:0]  con2;
	logic [7:0]  cmp_h;
	logic [7:0]  cmp_l;
	logic [7:0]  irq_en;
	logic [7:0]  dly;
	logic [7:0]  aindis;
	logic [7:0]  result_high_byte;
	logic [3:0]  result_low_nibble;
	logic        conv_done_flag;
	logic        compare_output;
	logic        fault_brake_flag;
	logic [7:0]  cnt;
	logic [1:0]  pin_s1;
	logic [1:0]  pin_s2;
	logic        trig_prev;

	// bus decode
	wire        req       = AVS_READ | AVS_WRITE;
	wire        wr        = AVS_WRITE & ~AVS_WAITREQUEST & AVS_BYTEENABLE[0];
	wire [7:0]  wd        = AVS_WRITEDATA[7:0];
	wire        wr_con0   = wr & (AVS_ADDRESS == sacc_pkg::OFS_CON0);
	wire        wr_con1   = wr & (AVS_ADDRESS == sacc_pkg::OFS_CON1);
	wire        wr_con2   = wr & (AVS_ADDRESS == sacc_pkg::OFS_CON2);
	wire        wr_cmp_h  = wr & (AVS_ADDRESS == sacc_pkg::OFS_CMP_H);
	wire        wr_cmp_l  = wr & (AVS_ADDRESS == sacc_pkg::OFS_CMP_L);
	wire        wr_brake  = wr & (AVS_ADDRESS == sacc_pkg::OFS_BRAKE);
	wire        wr_irqen  = wr & (AVS_ADDRESS == sacc_pkg::OFS_IRQEN);
	wire        wr_delay  = wr & (AVS_ADDRESS == sacc_pkg::OFS_DELAY);
	wire        wr_aindis = wr & (AVS_ADDRESS == sacc_pkg::OFS_AINDIS);

	// control fields
	wire        converter_enable      = con1[sacc_pkg::B_ENABLE];
	wire        hw_trigger_enable     = con1[sacc_pkg::B_HWTRIG];
	wire        start_pin_select      = con1[sacc_pkg::B_PINSEL];
	wire [1:0]  trigger_type_select   = con1[sacc_pkg::B_TYPE +: 2];
	wire [1:0]  trigger_source_select = con0[sacc_pkg::B_SRC +: 2];
	wire [3:0]  channel_select        = con0[sacc_pkg::B_CHAN +: 4];
	wire        comparator_enable     = con2[sacc_pkg::B_CMPEN];
	wire        compare_polarity      = con2[sacc_pkg::B_POL];
	wire        compare_brake_enable  = con2[sacc_pkg::B_BRKEN];
	wire        conv_start_busy       = (state == sacc_pkg::ST_CONV);

	// trigger selection
	wire        external_start_pin = start_pin_select ? pin_s2[1] : pin_s2[0];
	wire [2:0]  pwm_idx   = {trigger_source_select, 1'b0};
	wire        trig_lvl  = (trigger_source_select == sacc_pkg::SRC_PIN) ?
		external_start_pin : PWM_OUT[pwm_idx];
	wire        rise      = trig_lvl & ~trig_prev;
	wire        fall      = ~trig_lvl & trig_prev;
	wire        is_pwm    = (trigger_source_select != sacc_pkg::SRC_PIN);
	wire        trig_hit  = hw_trigger_enable & (
		((trigger_type_select == sacc_pkg::TYP_FALL) & fall) |
		((trigger_type_select == sacc_pkg::TYP_RISE) & rise) |
		((trigger_type_select == sacc_pkg::TYP_CENT) & is_pwm & PWM_CENTER) |
		((trigger_type_select == sacc_pkg::TYP_END) & is_pwm & PWM_PERIOD_END));

	// start sequencing
	wire        sw_req    = wr_con0 & wd[sacc_pkg::B_BUSY];
	wire        start_ok  = converter_enable & ~conv_done_flag;
	wire        idle      = (state == sacc_pkg::ST_IDLE);
	wire        dly_zero  = (dly == sacc_pkg::RST_BYTE);
	wire        dly_last  = (state == sacc_pkg::ST_DELAY) & (cnt == 8'h01);
	wire        start_now = start_ok & ((idle & (sw_req | (trig_hit & dly_zero))) | dly_last);
	wire        go_delay  = start_ok & idle & ~sw_req & trig_hit & ~dly_zero;
	wire        done_evt  = conv_start_busy & CONV_DONE;
	wire        hw_ready  = hw_trigger_enable & idle & start_ok & dly_zero & ~sw_req;
	// a channel written together with a start must already reach the core with that start
	wire [3:0]  sel_code  = wr_con0 ? wd[sacc_pkg::B_CHAN +: 4] : channel_select;

	// comparator
	wire [11:0] cmp_const = {cmp_h, cmp_l[3:0]};
	wire        cmp_ge    = (CONV_DATA >= cmp_const);
	wire        next_cmpo = cmp_ge ^ compare_polarity;
	wire        cmp_evt   = done_evt & comparator_enable & compare_brake_enable & next_cmpo & ~compare_output;

	// flags: a set in the same cycle as a clear wins
	wire        next_done = done_evt | (conv_done_flag & ~(wr_con0 & ~wd[sacc_pkg::B_DONE]));
	wire        brk_evt   = BRAKE_EVENT | cmp_evt;
	wire        next_fbf  = brk_evt | (fault_brake_flag & ~(wr_brake & ~wd[sacc_pkg::B_FBF]));

	// read mux
	wire [7:0]  rd_con0 = {conv_done_flag, conv_start_busy, con0[5:0]};
	wire [7:0]  rd_con2 = {con2[7:5], compare_output, 4'h0};
	wire [7:0]  rd_byte =
		(AVS_ADDRESS == sacc_pkg::OFS_CON0)   ? rd_con0 :
		(AVS_ADDRESS == sacc_pkg::OFS_CON1)   ? con1 :
		(AVS_ADDRESS == sacc_pkg::OFS_CON2)   ? rd_con2 :
		(AVS_ADDRESS == sacc_pkg::OFS_RES_H)  ? result_high_byte :
		(AVS_ADDRESS == sacc_pkg::OFS_RES_L)  ? {4'h0, result_low_nibble} :
		(AVS_ADDRESS == sacc_pkg::OFS_CMP_H)  ? cmp_h :
		(AVS_ADDRESS == sacc_pkg::OFS_CMP_L)  ? cmp_l :
		(AVS_ADDRESS == sacc_pkg::OFS_BRAKE)  ? {fault_brake_flag, 7'h00} :
		(AVS_ADDRESS == sacc_pkg::OFS_IRQEN)  ? irq_en :
		(AVS_ADDRESS == sacc_pkg::OFS_DELAY)  ? dly :
		(AVS_ADDRESS == sacc_pkg::OFS_AINDIS) ? aindis : sacc_pkg::RST_BYTE;

	// input selection, nothing connected when disabled or reserved
	logic [8:0] next_sel;
	genvar gi;
	generate
		for (gi = 0; gi < sacc_pkg::NSEL; gi++) begin : g_sel
			assign next_sel[gi] = converter_enable & (sel_code == 4'(gi));
		end
	endgenerate

	// bus answer: one wait cycle, then one cycle with waitrequest low
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			AVS_WAITREQUEST <= 1'b1;
			AVS_READDATA    <= 32'h0;
		end else begin
			AVS_WAITREQUEST <= ~(req & AVS_WAITREQUEST);
			AVS_READDATA    <= {24'h0, rd_byte};
		end
	end

	// software-written registers
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			con0   <= sacc_pkg::RST_BYTE;
			con1   <= sacc_pkg::RST_BYTE;
			con2   <= sacc_pkg::RST_BYTE;
			cmp_h  <= sacc_pkg::RST_BYTE;
			cmp_l  <= sacc_pkg::RST_BYTE;
			irq_en <= sacc_pkg::RST_BYTE;
			dly    <= sacc_pkg::RST_BYTE;
			aindis <= sacc_pkg::RST_BYTE;
		end else begin
			if (wr_con0)   con0   <= {2'h0, wd[5:0]};
			if (wr_con1)   con1   <= {1'b0, wd[6], 2'h0, wd[3:0]};
			if (wr_con2)   con2   <= {wd[7:5], 5'h00};
			if (wr_cmp_h)  cmp_h  <= wd;
			if (wr_cmp_l)  cmp_l  <= {4'h0, wd[3:0]};
			if (wr_irqen)  irq_en <= {6'h00, wd[1:0]};
			if (wr_delay)  dly    <= wd;
			if (wr_aindis) aindis <= wd;
		end
	end

	// start pin synchronisers and edge history
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			pin_s1    <= 2'h0;
			pin_s2    <= 2'h0;
			trig_prev <= 1'b0;
		end else begin
			pin_s1    <= {START_PIN_B, START_PIN_A};
			pin_s2    <= pin_s1;
			trig_prev <= trig_lvl;
		end
	end

	// conversion sequencer
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			state <= sacc_pkg::ST_IDLE;
			cnt   <= sacc_pkg::RST_BYTE;
		end else begin
			unique case (state)
				sacc_pkg::ST_IDLE: begin
					if (start_now) state <= sacc_pkg::ST_CONV;
					else if (go_delay) state <= sacc_pkg::ST_DELAY;
					cnt <= dly;
				end
				sacc_pkg::ST_DELAY: begin
					cnt <= cnt - 8'h01;
					if (!converter_enable) state <= sacc_pkg::ST_IDLE;
					else if (dly_last) state <= start_now ? sacc_pkg::ST_CONV : sacc_pkg::ST_IDLE;
				end
				sacc_pkg::ST_CONV: begin
					if (!converter_enable || CONV_DONE) state <= sacc_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// result, comparator and flags
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			result_high_byte  <= sacc_pkg::RST_BYTE;
			result_low_nibble <= 4'h0;
			compare_output    <= 1'b0;
			conv_done_flag    <= 1'b0;
			fault_brake_flag  <= 1'b0;
		end else begin
			if (done_evt) begin
				result_high_byte  <= CONV_DATA[11:4];
				result_low_nibble <= CONV_DATA[3:0];
			end
			if (done_evt && comparator_enable) compare_output <= next_cmpo;
			conv_done_flag   <= next_done;
			fault_brake_flag <= next_fbf;
		end
	end

	// outputs
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			CONV_POWER         <= 1'b0;
			ANALOG_SEL         <= 9'h000;
			DIGITAL_IN_DISABLE <= 8'h00;
			CONV_START         <= 1'b0;
			COMPARE_BRAKE      <= 1'b0;
			CONV_IRQ           <= 1'b0;
			FBRAKE_IRQ         <= 1'b0;
		end else begin
			CONV_POWER         <= converter_enable;
			ANALOG_SEL         <= next_sel;
			DIGITAL_IN_DISABLE <= aindis;
			CONV_START         <= start_now;
			COMPARE_BRAKE      <= cmp_evt;
			CONV_IRQ           <= next_done & irq_en[sacc_pkg::B_CIRQ];
			FBRAKE_IRQ         <= next_fbf & irq_en[sacc_pkg::B_FBIRQ];
		end
	end

	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RESET);

	sequence sw_accept_s;
		sw_req && idle && start_ok;
	endsequence
	sequence conv_begun_s;
		CONV_START && conv_start_busy;
	endsequence

	power_off_a: assert property (!converter_enable |=> !CONV_POWER && ANALOG_SEL == 9'h000)
		else $error("converter powered while disabled");
	sel_onehot_a: assert property (##1 $onehot0(ANALOG_SEL))
		else $error("more than one input selected");
	sw_start_a: assert property (sw_accept_s |=> conv_begun_s)
		else $error("software start not begun");
	done_busy_a: assert property (done_evt |=> !conv_start_busy && conv_done_flag)
		else $error("completion did not clear busy or set flag");
	result_split_a: assert property (done_evt |=> {result_high_byte, result_low_nibble} == $past(CONV_DATA))
		else $error("result bytes wrong");
	hw_busy_a: assert property (idle && trig_hit && dly_zero && start_ok && !sw_req |=> conv_begun_s)
		else $error("hardware start did not set busy");
	delay_wait_a: assert property (go_delay && dly == 8'h02 |=> !CONV_START ##1 start_ok |=> CONV_START)
		else $error("trigger delay wrong");
	busy_drop_a: assert property (conv_start_busy && !CONV_DONE && converter_enable |=> !CONV_START && conv_start_busy)
		else $error("start accepted while busy");
	cmp_hold_a: assert property (!done_evt |=> $stable(compare_output))
		else $error("compare output moved outside completion");
	cmp_sense_a: assert property (done_evt && comparator_enable |=> compare_output == ($past(cmp_ge) ^ $past(compare_polarity)))
		else $error("compare output sense wrong");
	brake_flag_a: assert property (BRAKE_EVENT || cmp_evt |=> fault_brake_flag)
		else $error("brake event lost");
	brake_irq_a: assert property (fault_brake_flag && irq_en[sacc_pkg::B_FBIRQ] |=> FBRAKE_IRQ == fault_brake_flag)
		else $error("brake interrupt missing");
	done_block_a: assert property (conv_done_flag |-> !start_now)
		else $error("start while done flag set");

	// further guards on bus, triggers, comparator and selection
	sequence start_pulse_s;
		CONV_START ##1 !CONV_START;
	endsequence
	sequence cmp_rise_s;
		COMPARE_BRAKE && compare_output && !$past(compare_output);
	endsequence

	start_once_a: assert property (sw_accept_s |=> start_pulse_s)
		else $error("software start pulse wrong");

	wait_answer_a: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
		else $error("bus request not answered");

	wait_single_a: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
		else $error("bus answer longer than one cycle");

	rd_upper_a: assert property (AVS_READDATA[31:8] == 24'h000000)
		else $error("read data upper bits set");

	irq_follow_a: assert property (conv_done_flag && irq_en[sacc_pkg::B_CIRQ] |=> CONV_IRQ == conv_done_flag)
		else $error("conversion interrupt wrong");

	done_hold_a: assert property (conv_done_flag && !wr_con0 |=> conv_done_flag)
		else $error("done flag lost without software");

	res_hold_a: assert property (!done_evt |=> $stable(result_high_byte) && $stable(result_low_nibble))
		else $error("result moved outside completion");

	power_on_a: assert property (converter_enable |=> CONV_POWER)
		else $error("converter not powered while enabled");

	dis_start_a: assert property (!converter_enable |=> !CONV_START)
		else $error("start while disabled");

	pwm0_src_a: assert property (trigger_source_select == sacc_pkg::SRC_PWM0 |-> trig_lvl == PWM_OUT[0])
		else $error("source code 0 not channel 0");

	pwm2_src_a: assert property (trigger_source_select == sacc_pkg::SRC_PWM2 |-> trig_lvl == PWM_OUT[2])
		else $error("source code 1 not channel 2");

	pwm4_src_a: assert property (trigger_source_select == sacc_pkg::SRC_PWM4 |-> trig_lvl == PWM_OUT[4])
		else $error("source code 2 not channel 4");

	pina_src_a: assert property (trigger_source_select == sacc_pkg::SRC_PIN && !start_pin_select |-> trig_lvl == pin_s2[0])
		else $error("start pin a not routed");

	pinb_src_a: assert property (trigger_source_select == sacc_pkg::SRC_PIN && start_pin_select |-> trig_lvl == pin_s2[1])
		else $error("start pin b not routed");

	rise_trig_a: assert property (hw_ready && trigger_type_select == sacc_pkg::TYP_RISE && trig_lvl && !trig_prev |=> CONV_START)
		else $error("rising trigger missed");

	fall_trig_a: assert property (hw_ready && trigger_type_select == sacc_pkg::TYP_FALL && !trig_lvl && trig_prev |=> CONV_START)
		else $error("falling trigger missed");

	cent_trig_a: assert property (hw_ready && trigger_type_select == sacc_pkg::TYP_CENT && is_pwm && PWM_CENTER |=> CONV_START)
		else $error("centre trigger missed");

	end_trig_a: assert property (hw_ready && trigger_type_select == sacc_pkg::TYP_END && is_pwm && PWM_PERIOD_END |=> CONV_START)
		else $error("period end trigger missed");

	pin_strobe_a: assert property (trigger_source_select == sacc_pkg::SRC_PIN && trigger_type_select[1] |-> !trig_hit)
		else $error("pin source fired on pwm point");

	delay_quiet_a: assert property (state == sacc_pkg::ST_DELAY && !dly_last |=> !CONV_START)
		else $error("start inside trigger delay");

	busy_sw_a: assert property (wr_con0 && wd[sacc_pkg::B_BUSY] && conv_start_busy |=> !CONV_START)
		else $error("software start taken while busy");

	cmp_off_a: assert property (done_evt && !comparator_enable |=> $stable(compare_output))
		else $error("comparator moved while disabled");

	brk_off_a: assert property (!compare_brake_enable || !comparator_enable |=> !COMPARE_BRAKE)
		else $error("compare brake while disabled");

	brk_rise_a: assert property (COMPARE_BRAKE |-> cmp_rise_s)
		else $error("compare brake without rising output");

	brk_pulse_a: assert property (COMPARE_BRAKE |=> !COMPARE_BRAKE)
		else $error("compare brake longer than one cycle");

	fbf_hold_a: assert property (fault_brake_flag && !wr_brake |=> fault_brake_flag)
		else $error("brake flag lost without software");

	bg_sel_a: assert property (converter_enable && channel_select == sacc_pkg::CHAN_BG && !wr_con0 |=> ANALOG_SEL == 9'h100)
		else $error("band-gap not selected");

	rsv_sel_a: assert property (channel_select > sacc_pkg::CHAN_BG && !wr_con0 |=> ANALOG_SEL == 9'h000)
		else $error("reserved code selected an input");

	din_copy_a: assert property (1'b1 |=> DIGITAL_IN_DISABLE == $past(aindis))
		else $error("digital input disable not copied");
endmodule : sacc_top
`default_nettype wire

//--- sim/sacc_core_model.sv
// behavioural analog core: converts the selected input after a set latency
`timescale 1ns/1ns
`default_nettype none
module sacc_core_model #(
	parameter int VREF_MV = 3000
) (
	// bench side
	input  wire logic        clk,
	input  wire logic [7:0]  lat,
	input  wire logic [11:0] mv [9],
	// control block side
	input  wire logic        power,
	input  wire logic [8:0]  sel,
	input  wire logic        start,
	output logic             done,
	output logic [11:0]      data
);
	int unsigned cnt = 0;
	logic [11:0] held = 12'h000;
	initial begin
		done = 1'b0;
		data = 12'h000;
	end
	always @(posedge clk) begin
		done <= 1'b0;
		// result lines invert each cycle outside the done cycle, so the last result shows only every other cycle
		data <= ~data;
		if (!power) begin
			cnt <= 0;
		end else if (cnt != 0) begin
			cnt <= cnt - 1;
			if (cnt == 1) begin
				done <= 1'b1;
				data <= held;
			end
		end else if (start) begin
			cnt <= (lat == 8'h00) ? 1 : int'(lat);
			held <= 12'h000;
			for (int i = 0; i < 9; i++) begin
				if (sel[i]) held <= 12'(4095 * int'(mv[i]) / VREF_MV);
			end
		end
	end
endmodule : sacc_core_model
`default_nettype wire

//--- sim/test_sar_adc_conversion_control.sv
// self-checking bench: register bus, conversions, triggers and comparator
`timescale 1ns/1ns
`default_nettype none
module test_sar_adc_conversion_control;
	logic        REF_CLK = 1'b0, RESET = 1'b1, AVS_READ = 1'b0, AVS_WRITE = 1'b0;
	logic [5:0]  AVS_ADDRESS = 6'h00, PWM_OUT = 6'h00;
	logic [31:0] AVS_WRITEDATA = 32'h0, AVS_READDATA;
	logic        AVS_WAITREQUEST, CONV_POWER, CONV_START, CONV_DONE, COMPARE_BRAKE, CONV_IRQ, FBRAKE_IRQ;
	logic        PWM_CENTER = 1'b0, PWM_PERIOD_END = 1'b0, BRAKE_EVENT = 1'b0, START_PIN_A = 1'b0, START_PIN_B = 1'b0;
	logic [8:0]  ANALOG_SEL;
	logic [7:0]  DIGITAL_IN_DISABLE, lat = 8'h04;
	logic [11:0] CONV_DATA, mv [9];
	logic [31:0] exp_q [$];
	// {pin select, source, type}
	logic [4:0]  tbl [7] = '{5'h01, 5'h04, 5'h09, 5'h02, 5'h07, 5'h0d, 5'h1c};
	int          n_errors = 0, n_checks = 0, n_starts = 0, n_brakes = 0, cycles = 0;
	sacc_top dut (.REF_CLK, .RESET, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_BYTEENABLE(4'hf), .AVS_WRITEDATA,
		.AVS_READDATA, .AVS_WAITREQUEST, .CONV_POWER, .ANALOG_SEL, .DIGITAL_IN_DISABLE, .CONV_START, .CONV_DONE,
		.CONV_DATA, .PWM_OUT, .PWM_CENTER, .PWM_PERIOD_END, .BRAKE_EVENT, .COMPARE_BRAKE, .START_PIN_A,
		.START_PIN_B, .CONV_IRQ, .FBRAKE_IRQ);
	sacc_core_model core (.clk(REF_CLK), .lat, .mv, .power(CONV_POWER), .sel(ANALOG_SEL), .start(CONV_START),
		.done(CONV_DONE), .data(CONV_DATA));
	always #20 REF_CLK = ~REF_CLK;
	task automatic wrap_up;
		if (n_errors == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : wrap_up
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
		@(posedge REF_CLK);
		AVS_ADDRESS <= a;
		AVS_WRITE <= w;
		AVS_READ <= !w;
		AVS_WRITEDATA <= {24'h0, d};
		do @(posedge REF_CLK); while (AVS_WAITREQUEST !== 1'b0);
		AVS_WRITE <= 1'b0;
		AVS_READ <= 1'b0;
	endtask : bus
	task automatic rd(input logic [5:0] a, input logic [7:0] e);
		exp_q.push_back({24'h0, e});
		bus(1'b0, a, 8'h00);
	endtask : rd
	task automatic wait_done;
		int k;
		k = 0;
		while (CONV_IRQ !== 1'b1 && k < 300) begin
			@(posedge REF_CLK);
			k++;
		end
		check("conv_irq", 32'(CONV_IRQ), 32'h1);
	endtask : wait_done
	// level on the selected pwm channel or pin, or a centre/end strobe
	task automatic evt(input logic [4:0] t, input logic v);
		@(posedge REF_CLK);
		if (t[1]) begin
			PWM_CENTER <= !v;
			PWM_PERIOD_END <= v;
			@(posedge REF_CLK);
			PWM_CENTER <= 1'b0;
			PWM_PERIOD_END <= 1'b0;
		end else if (t[3:2] != sacc_pkg::SRC_PIN) PWM_OUT[2 * t[3:2]] <= v;
		else if (t[4]) START_PIN_B <= v;
		else START_PIN_A <= v;
	endtask : evt
	function automatic logic [11:0] code_of(input int i);
		return 12'(4095 * int'(mv[i]) / 3000);
	endfunction : code_of
	always @(posedge REF_CLK) begin
		cycles++;
		if (CONV_START === 1'b1) n_starts++;
		if (COMPARE_BRAKE === 1'b1) n_brakes++;
		if (AVS_READ === 1'b1 && AVS_WAITREQUEST === 1'b0 && exp_q.size() > 0)
			check("readdata", AVS_READDATA, exp_q.pop_front());
		if (cycles == 30000) begin
			n_errors++;
			wrap_up();
		end
	end
	initial begin
		int s, k, d;
		logic [11:0] cst;
		logic co, prev, pol;
		logic [3:0] ch;
		void'($urandom(32'ha4b8ba1d));
		foreach (mv[i]) mv[i] = 12'($urandom % 3001);
		mv[2] = 12'd1000;
		mv[3] = 12'd2000;
		repeat (5) @(posedge REF_CLK);
		RESET <= 1'b0;
		rd(sacc_pkg::OFS_CON0, 8'h00);
		rd(sacc_pkg::OFS_CON2, 8'h00);
		bus(1'b1, 6'h3c, 8'hff);
		rd(6'h3c, 8'h00);
		bus(1'b1, sacc_pkg::OFS_IRQEN, 8'h03);
		bus(1'b1, sacc_pkg::OFS_CON1, 8'h01);
		repeat (2) @(posedge REF_CLK);
		check("power", 32'(CONV_POWER), 32'h1);
		for (int c = 0; c < 9; c++) begin
			lat <= 8'(1 + $urandom % 16);
			bus(1'b1, sacc_pkg::OFS_CON0, 8'h40 | 8'(c));
			wait_done();
			check("sel", 32'(ANALOG_SEL), 32'h1 << c);
			rd(sacc_pkg::OFS_CON0, 8'h80 | 8'(c));
			rd(sacc_pkg::OFS_RES_H, 8'(code_of(c) >> 4));
			rd(sacc_pkg::OFS_RES_L, 8'(code_of(c) & 12'h00f));
			bus(1'b1, sacc_pkg::OFS_CON0, 8'(c));
			repeat (2) @(posedge REF_CLK);
			check("irq clear", 32'(CONV_IRQ), 32'h0);
		end
		bus(1'b1, sacc_pkg::OFS_CON0, 8'h09);
		repeat (2) @(posedge REF_CLK);
		check("reserved sel", 32'(ANALOG_SEL), 32'h0);
		lat <= 8'd60;
		s = n_starts;
		bus(1'b1, sacc_pkg::OFS_CON0, 8'h41);
		bus(1'b1, sacc_pkg::OFS_CON0, 8'h41);
		rd(sacc_pkg::OFS_CON0, 8'h41);
		wait_done();
		// done flag still set: a new start must be dropped
		bus(1'b1, sacc_pkg::OFS_CON0, 8'hc1);
		repeat (3) @(posedge REF_CLK);
		check("starts", 32'(n_starts - s), 32'h1);
		bus(1'b1, sacc_pkg::OFS_CON0, 8'h01);
		foreach (tbl[i]) begin
			d = $urandom % 8;
			bus(1'b1, sacc_pkg::OFS_DELAY, 8'(d));
			if (!tbl[i][1]) evt(tbl[i], tbl[i][0]);
			// switch source and pin with triggers off, so the switch itself is no edge
			bus(1'b1, sacc_pkg::OFS_CON1, {1'b0, tbl[i][4], 2'b00, tbl[i][1:0], 2'b01});
			bus(1'b1, sacc_pkg::OFS_CON0, {2'b00, tbl[i][3:2], 4'h5});
			bus(1'b1, sacc_pkg::OFS_CON1, {1'b0, tbl[i][4], 2'b00, tbl[i][1:0], 2'b11});
			s = n_starts;
			evt(tbl[i], !tbl[i][0]);
			repeat (12) @(posedge REF_CLK);
			check("wrong event", 32'(n_starts - s), 32'h0);
			lat <= 8'd30;
			evt(tbl[i], tbl[i][0]);
			k = 0;
			while (CONV_START !== 1'b1 && k < 30) begin
				@(posedge REF_CLK);
				k++;
			end
			check("trigger delay", 32'(k >= d && k <= d + 8), 32'h1);
			rd(sacc_pkg::OFS_CON0, {2'b01, tbl[i][3:2], 4'h5});
			wait_done();
			bus(1'b1, sacc_pkg::OFS_CON0, {2'b00, tbl[i][3:2], 4'h5});
		end
		bus(1'b1, sacc_pkg::OFS_CON1, 8'h01);
		cst = code_of(3);
		bus(1'b1, sacc_pkg::OFS_CMP_H, 8'(cst >> 4));
		bus(1'b1, sacc_pkg::OFS_CMP_L, 8'(cst & 12'h00f));
		prev = 1'b0;
		for (int j = 0; j < 4; j++) begin
			ch = (j == 1 || j == 3) ? 4'h2 : 4'h3;
			pol = (j >= 2);
			co = (code_of(ch) >= cst) ^ pol;
			bus(1'b1, sacc_pkg::OFS_CON2, {1'b1, pol, 1'b1, 5'h00});
			s = n_brakes;
			bus(1'b1, sacc_pkg::OFS_CON0, {4'h4, ch});
			wait_done();
			rd(sacc_pkg::OFS_CON2, {1'b1, pol, 1'b1, co, 4'h0});
			check("brakes", 32'(n_brakes - s), 32'(co && !prev));
			rd(sacc_pkg::OFS_BRAKE, (co && !prev) ? 8'h80 : 8'h00);
			check("brake irq", 32'(FBRAKE_IRQ), 32'(co && !prev));
			bus(1'b1, sacc_pkg::OFS_BRAKE, 8'h00);
			bus(1'b1, sacc_pkg::OFS_CON0, {4'h0, ch});
			prev = co;
		end
		bus(1'b1, sacc_pkg::OFS_CMP_H, 8'h00);
		rd(sacc_pkg::OFS_CON2, 8'hf0);
		bus(1'b1, sacc_pkg::OFS_IRQEN, 8'h01);
		@(posedge REF_CLK);
		BRAKE_EVENT <= 1'b1;
		@(posedge REF_CLK);
		BRAKE_EVENT <= 1'b0;
		rd(sacc_pkg::OFS_BRAKE, 8'h80);
		check("brake irq masked", 32'(FBRAKE_IRQ), 32'h0);
		bus(1'b1, sacc_pkg::OFS_IRQEN, 8'h03);
		repeat (2) @(posedge REF_CLK);
		check("brake irq on", 32'(FBRAKE_IRQ), 32'h1);
		bus(1'b1, sacc_pkg::OFS_CON1, 8'h00);
		repeat (2) @(posedge REF_CLK);
		check("power off", 32'({CONV_POWER, ANALOG_SEL}), 32'h0);
		wrap_up();
	end
endmodule : test_sar_adc_conversion_control
`default_nettype wire
